/* include/mmr_params.svh */
// Offsets, bit positions, reset values and counts of the mode registers
`ifndef MMR_PARAMS_SVH
`define MMR_PARAMS_SVH
`define MMR_A_CTL      3'h0
`define MMR_A_MODE     3'h1
`define MMR_A_MAF      3'h2
`define MMR_A_FLUSH    3'h3
`define MMR_A_ALT      3'h4
`define MMR_CTL_RST    6'h00
`define MMR_MODE_RST   4'h0
`define MMR_MAF_RST    6'h00
`define MMR_ALT_RST    2'h0
`define MMR_CTL_BSWAP  0
`define MMR_CTL_DM_LO  1
`define MMR_CTL_DM_HI  2
`define MMR_CTL_SHBO   4
`define MMR_MD_ENA     0
`define MMR_MD_FHIT    1
`define MMR_MD_PINV    2
`define MMR_MD_POFF    3
`define MMR_MF_LDNM    0
`define MMR_MF_FLUSH   1
`define MMR_MF_STNM    2
`define MMR_MF_IONM    3
`define MMR_MF_AGEOFF  4
`define MMR_MF_ARB     5
`define MMR_ALT_LSB    3
`define MMR_ALT_MSB    4
`define MMR_PA_SWAP    2
`define MMR_PA_IO      39
`define MMR_HI_SEL     2'h2
`define MMR_LO_SEL     13'h1ffe
`define MMR_AGE_CYC    64
`define MMR_AGE_LAST   7'h3f
`endif

/* include/mmr_pkg.sv */
// Types shared by the memory unit mode register bank
package mmr_pkg;
  typedef enum logic [1:0] {
    MMR_KERNEL = 2'h0,
    MMR_EXEC   = 2'h1,
    MMR_SUPER  = 2'h2,
    MMR_USER   = 2'h3
  } mmr_alt_t;
  typedef struct packed {
    logic        valid;
    logic        kernel;
    logic        longword;
    logic [42:0] va;
    logic [39:0] tb_pa;
  } mmr_xl_req_t;
  typedef struct packed {
    logic        valid;
    logic        direct;
    logic [39:0] pa;
  } mmr_xl_rsp_t;
  typedef struct packed {
    logic       lookup_hit;
    logic       store;
    logic       int_store;
    logic       fill;
    logic [7:0] data_par;
    logic       par_err;
  } mmr_dc_in_t;
  typedef struct packed {
    logic       hit;
    logic       wr_en;
    logic [7:0] data_par;
    logic       par_report;
  } mmr_dc_out_t;
  typedef struct packed {
    logic ld_issue;
    logic ld_io;
    logic ld_entry_locked;
    logic st_issue;
    logic st_entry_locked;
    logic wb_valid;
    logic wb_alloc;
    logic ldl_issue;
    logic ld_req;
    logic wb_req;
    logic other_req;
    logic ld_pending;
    logic store_outstanding;
  } mmr_maf_in_t;
  typedef struct packed {
    logic ld_merge_ok;
    logic ld_lock_new;
    logic st_merge_ok;
    logic st_lock_new;
    logic wb_flush;
    logic wb_age_req;
    logic ld_arb;
    logic wb_arb;
    logic other_arb;
  } mmr_maf_out_t;
endpackage

/* rtl/mmr_top.sv */
// Memory unit mode registers and the datapath controls they steer
`timescale 1ns/1ps
`include "mmr_params.svh"

// How it works
// - Chip reset clears control, cache mode; timeout keeps
// - Miss mode cleared; arbiter block also on timeout
// - Byte swap inverts address bit 2, longwords
// - Upper direct map passes va 39:13
// - Lower direct map zeroes pa 39:30
// - Direct mapping used only in kernel mode
// - Lower direct map also selects compact format
// - Compact format builds table entry address from va 31:13
// - Shifter byte order complements shift amount
// - Cache disable blocks updates, loads miss unless force hit is set
// - Force hit makes every reference hit
// - Parity invert flips integer store hit parity
// - Report disable suppresses cache parity errors
// - Load merge off allocates permanently unmergeable entries
// - Flush always drains nonempty write buffer
// - Store merge off allocates permanently unmergeable entries
// - I/O load merge off blocks bit-39 merges
// - Aging off: request on locked load, second
// - Arbiter block stops load and buffer requests
// - Read-only bits show outstanding requests
// - Any flush write clears all valid bits
// - Alternate mode held: kernel, executive, supervisor, user codes
module mmr_top
  import mmr_pkg::*;
(
  // Clock and resets
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic         TMO_RST,
  // Register port
  input  wire logic [2:0]   ADDR,
  input  wire logic [63:0]  WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic      [63:0]  RDATA,
  // Address translation
  input  mmr_xl_req_t       XL_REQ,
  output mmr_xl_rsp_t       XL_RSP,
  // Fault address formatting
  input  wire logic [42:0]  FAULT_VA,
  input  wire logic [63:0]  PT_BASE,
  output logic      [63:0]  FMT_ADDR,
  // Integer shifter
  input  wire logic [5:0]   SH_AMT_IN,
  output logic      [5:0]   SH_AMT,
  // Data cache
  input  mmr_dc_in_t        DC_IN,
  output mmr_dc_out_t       DC_OUT,
  output logic              L1D_FLUSH_TRIGGER_ALL,
  // Miss file and write buffer
  input  mmr_maf_in_t       MAF_IN,
  output mmr_maf_out_t      MAF_OUT,
  // Alternate privilege mode
  output mmr_alt_t          ALTERNATE_PRIVILEGE_MODE
);

  logic [5:0]   ctl_ff;
  logic [3:0]   mode_ff;
  logic [5:0]   maf_ff;
  mmr_alt_t     alt_ff;
  logic         ld_pend_ff;
  logic         wb_pend_ff;
  logic [63:0]  rdata_ff;
  logic [63:0]  nxt_rdata;
  mmr_xl_rsp_t  xl_ff;
  mmr_xl_rsp_t  nxt_xl;
  logic [63:0]  fmt_ff;
  logic [63:0]  nxt_fmt;
  logic [5:0]   sh_ff;
  mmr_dc_out_t  dc_ff;
  mmr_dc_out_t  nxt_dc;
  logic         flush_ff;
  mmr_maf_out_t maf_out_ff;
  mmr_maf_out_t nxt_maf_out;
  logic [6:0]   age_ff;
  logic [6:0]   nxt_age;

  // Register decode
  wire wr_ctl   = WR && (ADDR == `MMR_A_CTL);
  wire wr_mode  = WR && (ADDR == `MMR_A_MODE);
  wire wr_maf   = WR && (ADDR == `MMR_A_MAF);
  wire wr_flush = WR && (ADDR == `MMR_A_FLUSH);
  wire wr_alt   = WR && (ADDR == `MMR_A_ALT);

  // Control register bits
  wire bswap   = ctl_ff[`MMR_CTL_BSWAP];
  wire dm_lo   = ctl_ff[`MMR_CTL_DM_LO];
  wire dm_hi   = ctl_ff[`MMR_CTL_DM_HI];
  wire shbo    = ctl_ff[`MMR_CTL_SHBO];

  // Cache mode bits
  wire l1d_enable  = mode_ff[`MMR_MD_ENA];
  wire l1d_force_hit = mode_ff[`MMR_MD_FHIT];
  wire dc_pinv = mode_ff[`MMR_MD_PINV];
  wire dc_poff = mode_ff[`MMR_MD_POFF];

  // Miss mode bits
  wire ld_nm   = maf_ff[`MMR_MF_LDNM];
  wire fl_alw  = maf_ff[`MMR_MF_FLUSH];
  wire st_nm   = maf_ff[`MMR_MF_STNM];
  wire io_nm   = maf_ff[`MMR_MF_IONM];
  wire age_off = maf_ff[`MMR_MF_AGEOFF];
  wire arb_blk = maf_ff[`MMR_MF_ARB];

  // Read values of the readable registers
  wire [63:0] rd_ctl  = {58'h0, ctl_ff};
  wire [63:0] rd_mode = {60'h0, mode_ff};
  wire [63:0] rd_maf  = {56'h0, wb_pend_ff, ld_pend_ff, maf_ff};

  // Read select; write-only and unmapped read as zero
  always_comb
  begin
    nxt_rdata = 64'h0;
    if (RD)
    begin
      unique case (ADDR)
        `MMR_A_CTL:  nxt_rdata = rd_ctl;
        `MMR_A_MODE: nxt_rdata = rd_mode;
        `MMR_A_MAF:  nxt_rdata = rd_maf;
        default:     nxt_rdata = 64'h0;
      endcase
    end
  end

  // Control register; only chip reset clears it
  always_ff @(posedge CLK)
  begin
    if (RST)
      ctl_ff <= `MMR_CTL_RST;
    else if (wr_ctl)
      ctl_ff <= WDATA[5:0];
  end

  // Cache mode register; only chip reset clears it
  always_ff @(posedge CLK)
  begin
    if (RST)
      mode_ff <= `MMR_MODE_RST;
    else if (wr_mode)
      mode_ff <= WDATA[3:0];
  end

  // Miss mode: arbiter block also drops on timeout
  always_ff @(posedge CLK)
  begin
    if (RST)
      maf_ff <= `MMR_MAF_RST;
    else if (wr_maf)
      maf_ff <= WDATA[5:0];
    else if (TMO_RST)
      maf_ff[`MMR_MF_ARB] <= 1'b0;
  end

  // Alternate mode; all four codes legal
  always_ff @(posedge CLK)
  begin
    if (RST)
      alt_ff <= mmr_alt_t'(`MMR_ALT_RST);
    else if (wr_alt)
      alt_ff <= mmr_alt_t'(WDATA[`MMR_ALT_MSB:`MMR_ALT_LSB]);
  end

  // Read data, standing one cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (RST)
      rdata_ff <= 64'h0;
    else
      rdata_ff <= nxt_rdata;
  end

  // Pending status sampled from the miss file
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ld_pend_ff <= 1'b0;
      wb_pend_ff <= 1'b0;
    end
    else
    begin
      ld_pend_ff <= MAF_IN.ld_pending;
      wb_pend_ff <= MAF_IN.store_outstanding;
    end
  end

  // Flush pulse, one cycle per write of any value
  always_ff @(posedge CLK)
  begin
    if (RST)
      flush_ff <= 1'b0;
    else
      flush_ff <= wr_flush;
  end

  // Direct map matches, kernel only
  wire hi_hit = XL_REQ.kernel && dm_hi
                && (XL_REQ.va[42:41] == `MMR_HI_SEL);
  wire lo_hit = XL_REQ.kernel && dm_lo
                && (XL_REQ.va[42:30] == `MMR_LO_SEL);
  wire [39:0] pa_hi = {XL_REQ.va[39:13], XL_REQ.tb_pa[12:0]};
  wire [39:0] pa_lo = {10'h0, XL_REQ.va[29:13],
                       XL_REQ.tb_pa[12:0]};
  wire [39:0] pa_sel = hi_hit ? pa_hi :
                       lo_hit ? pa_lo : XL_REQ.tb_pa;
  wire swap = bswap && XL_REQ.longword;
  always_comb
  begin
    nxt_xl        = '0;
    nxt_xl.valid  = XL_REQ.valid;
    nxt_xl.direct = hi_hit || lo_hit;
    nxt_xl.pa     = pa_sel;
    nxt_xl.pa[`MMR_PA_SWAP] = pa_sel[`MMR_PA_SWAP] ^ swap;
  end

  // Formatted fault address, layout picked by lower map bit
  wire [63:0] fmt_wide = {PT_BASE[63:33], FAULT_VA[42:13], 3'h0};
  wire [63:0] fmt_cmp  = {PT_BASE[63:30], 8'h0, FAULT_VA[31:13],
                          3'h0};
  always_comb
  begin
    nxt_fmt = dm_lo ? fmt_cmp : fmt_wide;
  end

  // Data cache qualifiers
  wire ld_hit  = l1d_force_hit || (l1d_enable && DC_IN.lookup_hit);
  wire upd     = l1d_enable && (DC_IN.store || DC_IN.fill);
  wire par_flp = dc_pinv && DC_IN.int_store && ld_hit;
  always_comb
  begin
    nxt_dc            = '0;
    nxt_dc.hit        = ld_hit;
    nxt_dc.wr_en      = upd;
    nxt_dc.data_par   = DC_IN.data_par ^ {8{par_flp}};
    nxt_dc.par_report = DC_IN.par_err && !dc_poff;
  end

  // Write buffer aging counter
  wire age_run  = MAF_IN.wb_valid && !age_off;
  wire age_done = age_run && (age_ff == `MMR_AGE_LAST);
  wire second   = MAF_IN.wb_alloc && MAF_IN.wb_valid;
  wire age_req  = age_off ? (MAF_IN.ldl_issue || second)
                          : age_done;
  always_comb
  begin
    nxt_age = 7'h0;
    if (age_run && !age_done)
      nxt_age = age_ff + 7'h1;
  end

  // Merge, flush and arbitration qualifiers
  wire ld_io_blk = io_nm && MAF_IN.ld_io;
  always_comb
  begin
    nxt_maf_out = '0;
    nxt_maf_out.ld_merge_ok = MAF_IN.ld_issue && !ld_nm
                              && !ld_io_blk
                              && !MAF_IN.ld_entry_locked;
    nxt_maf_out.ld_lock_new = MAF_IN.ld_issue && ld_nm;
    nxt_maf_out.st_merge_ok = MAF_IN.st_issue && !st_nm
                              && !MAF_IN.st_entry_locked;
    nxt_maf_out.st_lock_new = MAF_IN.st_issue && st_nm;
    nxt_maf_out.wb_flush    = fl_alw && MAF_IN.wb_valid;
    nxt_maf_out.wb_age_req  = age_req;
    nxt_maf_out.ld_arb      = MAF_IN.ld_req && !arb_blk;
    nxt_maf_out.wb_arb      = MAF_IN.wb_req && !arb_blk;
    nxt_maf_out.other_arb   = MAF_IN.other_req;
  end

  // Shift amount, complemented for reversed byte order
  wire [5:0] nxt_sh = shbo ? ~SH_AMT_IN : SH_AMT_IN;

  // Translation response register
  always_ff @(posedge CLK)
  begin
    if (RST)
      xl_ff <= '0;
    else
      xl_ff <= nxt_xl;
  end

  // Formatted fault address register
  always_ff @(posedge CLK)
  begin
    if (RST)
      fmt_ff <= 64'h0;
    else
      fmt_ff <= nxt_fmt;
  end

  // Shift amount register
  always_ff @(posedge CLK)
  begin
    if (RST)
      sh_ff <= 6'h0;
    else
      sh_ff <= nxt_sh;
  end

  // Cache qualifier register
  always_ff @(posedge CLK)
  begin
    if (RST)
      dc_ff <= '0;
    else
      dc_ff <= nxt_dc;
  end

  // Miss file qualifier register
  always_ff @(posedge CLK)
  begin
    if (RST)
      maf_out_ff <= '0;
    else
      maf_out_ff <= nxt_maf_out;
  end

  // Aging counter; restarts when the buffer empties
  always_ff @(posedge CLK)
  begin
    if (RST)
      age_ff <= 7'h0;
    else
      age_ff <= nxt_age;
  end

  // Outputs straight from flip-flops
  assign RDATA        = rdata_ff;
  assign XL_RSP       = xl_ff;
  assign FMT_ADDR     = fmt_ff;
  assign SH_AMT       = sh_ff;
  assign DC_OUT       = dc_ff;
  assign L1D_FLUSH_TRIGGER_ALL = flush_ff;
  assign MAF_OUT      = maf_out_ff;
  assign ALTERNATE_PRIVILEGE_MODE     = alt_ff;

endmodule

/* verif/mmr_chk.sv */
// Concurrent checks on the mode register bank datapath controls
`timescale 1ns/1ps
`include "mmr_params.svh"
module mmr_chk
  import mmr_pkg::*;
(
  // Clock, resets and writes
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        TMO_RST,
  input wire logic [2:0]  ADDR,
  input wire logic [63:0] WDATA,
  input wire logic        WR,
  // Datapath groups
  input wire logic [5:0]  SH_AMT_IN,
  input wire logic [5:0]  SH_AMT,
  input mmr_dc_in_t       DC_IN,
  input mmr_dc_out_t      DC_OUT,
  input wire logic        L1D_FLUSH_TRIGGER_ALL,
  input mmr_maf_in_t      MAF_IN,
  input mmr_maf_out_t     MAF_OUT
);
  logic [5:0] ctl_ff;
  logic [3:0] md_ff;
  logic [5:0] mf_ff;
  // Shadow copies of the writable mode bits
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctl_ff <= 6'h00;
      md_ff  <= 4'h0;
      mf_ff  <= 6'h00;
    end
    else
    begin
      if (WR && ADDR == `MMR_A_CTL) ctl_ff <= WDATA[5:0];
      if (WR && ADDR == `MMR_A_MODE) md_ff <= WDATA[3:0];
      if (WR && ADDR == `MMR_A_MAF) mf_ff <= WDATA[5:0];
      else if (TMO_RST) mf_ff[5] <= 1'b0;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_shift_order: assert property (!$past(RST) |-> SH_AMT ==
    ($past(ctl_ff[4]) ? ~$past(SH_AMT_IN) : $past(SH_AMT_IN)))
    else $error("shift amount wrong");
  a_cache_ena: assert property (!$past(RST) |->
    DC_OUT.hit == $past(md_ff[1] | md_ff[0] & DC_IN.lookup_hit)
    && DC_OUT.wr_en == $past(md_ff[0] & (DC_IN.store | DC_IN.fill)))
    else $error("cache hit or write enable wrong");
  a_par_invert: assert property (!$past(RST) |->
    DC_OUT.data_par == ($past(DC_IN.data_par) ^ {8{$past(md_ff[2]
    & DC_IN.int_store & (md_ff[1] | md_ff[0] & DC_IN.lookup_hit))}}))
    else $error("store parity wrong");
  a_par_report: assert property (!$past(RST) |->
    DC_OUT.par_report == $past(DC_IN.par_err & !md_ff[3]))
    else $error("parity report wrong");
  a_flush_pulse: assert property (!$past(RST) |->
    L1D_FLUSH_TRIGGER_ALL == $past(WR && ADDR == `MMR_A_FLUSH))
    else $error("flush pulse wrong");
  a_wb_flush: assert property (!$past(RST) |->
    MAF_OUT.wb_flush == $past(mf_ff[1] & MAF_IN.wb_valid))
    else $error("buffer flush wrong");
  a_load_merge: assert property (!$past(RST) |->
    MAF_OUT.ld_merge_ok == $past(MAF_IN.ld_issue & !mf_ff[0]
    & !(mf_ff[3] & MAF_IN.ld_io) & !MAF_IN.ld_entry_locked)
    && MAF_OUT.ld_lock_new == $past(MAF_IN.ld_issue & mf_ff[0]))
    else $error("load merge wrong");
  a_store_merge: assert property (!$past(RST) |->
    MAF_OUT.st_merge_ok == $past(MAF_IN.st_issue & !mf_ff[2]
    & !MAF_IN.st_entry_locked)
    && MAF_OUT.st_lock_new == $past(MAF_IN.st_issue & mf_ff[2]))
    else $error("store merge wrong");
  a_arb_block: assert property (!$past(RST) |->
    MAF_OUT.ld_arb == $past(MAF_IN.ld_req & !mf_ff[5])
    && MAF_OUT.wb_arb == $past(MAF_IN.wb_req & !mf_ff[5])
    && MAF_OUT.other_arb == $past(MAF_IN.other_req))
    else $error("arbitration gating wrong");
endmodule

/* verif/tb.sv */
// Self-checking bench for the memory unit mode register bank
`timescale 1ns/1ps
`include "mmr_params.svh"
module tb
  import mmr_pkg::*;
;
  typedef struct packed {
    logic [2:0]  a;
    logic [63:0] d;
    logic [63:0] e;
  } mmr_row_t;
  logic         CLK = 1'b0;
  logic         RST = 1'b1;
  logic         TMO_RST = 1'b0;
  logic [2:0]   ADDR = 3'h0;
  logic [63:0]  WDATA = 64'h0;
  logic         WR = 1'b0;
  logic         RD = 1'b0;
  logic [63:0]  RDATA;
  logic [42:0]  FAULT_VA = 43'h0;
  logic [63:0]  PT_BASE = 64'h0;
  logic [63:0]  FMT_ADDR;
  logic [5:0]   SH_AMT_IN = 6'h00;
  logic [5:0]   SH_AMT;
  logic         L1D_FLUSH_TRIGGER_ALL;
  mmr_xl_req_t  XL_REQ = '0;
  mmr_xl_rsp_t  XL_RSP;
  mmr_dc_in_t   DC_IN = '0;
  mmr_dc_out_t  DC_OUT;
  mmr_maf_in_t  MAF_IN = '0;
  mmr_maf_out_t MAF_OUT;
  mmr_alt_t     ALTERNATE_PRIVILEGE_MODE;
  int           fails = 0;
  int           tests_run = 0;
  int           n;
  logic [63:0]  rv;
  logic [42:0]  va;
  logic [39:0]  tp = 40'h96_5a5a_5a5a;
  mmr_row_t     rows [8] = '{
    '{3'h0, 64'hffff_ffff_ffff_ffd5, 64'h15},
    '{3'h0, 64'h2a, 64'h2a},
    '{3'h1, 64'hffff_ffff_ffff_fff5, 64'h5},
    '{3'h1, 64'ha, 64'ha},
    '{3'h2, 64'hffff_ffff_ffff_ffff, 64'h3f},
    '{3'h3, 64'hffff_ffff_ffff_ffff, 64'h0},
    '{3'h4, 64'hffff_ffff_ffff_ffff, 64'h0},
    '{3'h5, 64'hffff_ffff_ffff_ffff, 64'h0}};

  // Device under test
  mmr_top i_dut (.CLK, .RST, .TMO_RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .XL_REQ, .XL_RSP, .FAULT_VA, .PT_BASE, .FMT_ADDR, .SH_AMT_IN, .SH_AMT,
    .DC_IN, .DC_OUT, .L1D_FLUSH_TRIGGER_ALL, .MAF_IN, .MAF_OUT, .ALTERNATE_PRIVILEGE_MODE);

  // Clock
  always #5 CLK = ~CLK;

  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [63:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // One-cycle register read, data in the following cycle
  task automatic rd(input logic [2:0] a, output logic [63:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  // Translation request and response compare
  task automatic xl(input logic k, lw, input logic [42:0] v,
                    input logic ed, input logic [39:0] ep);
    @(posedge CLK);
    XL_REQ <= '{1'b1, k, lw, v, tp};
    @(posedge CLK);
    #1 chk({XL_RSP.valid, XL_RSP.direct, XL_RSP.pa}, {1'b1, ed, ep});
  endtask

  // Verdict
  task automatic stop_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk(rv, rows[i].e);
    end
    $display("register rows done");
    wr(`MMR_A_CTL, 64'h3f);
    wr(`MMR_A_MODE, 64'hf);
    wr(`MMR_A_MAF, 64'h3f);
    @(posedge CLK) TMO_RST <= 1'b1;
    @(posedge CLK) TMO_RST <= 1'b0;
    rd(`MMR_A_CTL, rv);
    chk(rv, 64'h3f);
    rd(`MMR_A_MODE, rv);
    chk(rv, 64'hf);
    rd(`MMR_A_MAF, rv);
    chk(rv, 64'h1f);
    @(posedge CLK) RST <= 1'b1;
    @(posedge CLK) RST <= 1'b0;
    for (int a = 0; a < 3; a++)
    begin
      rd(3'(a), rv);
      chk(rv, 64'h0);
    end
    $display("reset test done");
    @(posedge CLK) MAF_IN.ld_pending <= 1'b1;
    rd(`MMR_A_MAF, rv);
    chk(rv[7:6], 2'b01);
    @(posedge CLK) MAF_IN <= '{store_outstanding: 1'b1, default: 1'b0};
    rd(`MMR_A_MAF, rv);
    chk(rv[7:6], 2'b10);
    for (int m = 0; m < 4; m++)
    begin
      wr(`MMR_A_ALT, 64'hffff_ffff_ffff_ffe7 | 64'(m) << 3);
      @(posedge CLK);
      #1 chk(64'(ALTERNATE_PRIVILEGE_MODE), 64'(m));
    end
    wr(`MMR_A_CTL, 64'h07);
    va = {2'h2, 1'b1, 27'h2a5_a5a5, 13'h1fff};
    xl(1'b1, 1'b0, va, 1'b1, {va[39:13], tp[12:0]});
    xl(1'b0, 1'b0, va, 1'b0, tp);
    va = {13'h1ffe, 17'h1_5a5a, 13'h0aaa};
    xl(1'b1, 1'b0, va, 1'b1, {10'h0, va[29:13], tp[12:0]});
    xl(1'b1, 1'b1, 43'h0, 1'b0, tp ^ 40'h4);
    @(posedge CLK);
    FAULT_VA <= 43'h5a5_a5a5_a5a5;
    PT_BASE <= 64'hc3c3_3c3c_a5a5_5a5a;
    @(posedge CLK);
    #1 chk(FMT_ADDR, {PT_BASE[63:30], 8'h0, FAULT_VA[31:13], 3'h0});
    wr(`MMR_A_CTL, 64'h05);
    @(posedge CLK);
    #1 chk(FMT_ADDR, {PT_BASE[63:33], FAULT_VA[42:13], 3'h0});
    $display("translation and format done");
    for (int j = 0; j < 4; j++)
    begin
      wr(`MMR_A_CTL, 64'(j << 4));
      wr(`MMR_A_MODE, 64'(j * 5));
      wr(`MMR_A_MAF, 64'(j * 21));
      for (int i = 0; i < 64; i++)
      begin
        @(posedge CLK);
        SH_AMT_IN <= 6'(i);
        DC_IN <= mmr_dc_in_t'(13'(i * 397 + j));
        MAF_IN <= mmr_maf_in_t'(13'(i * 1231 + j * 7));
      end
    end
    $display("datapath sweep done");
    wr(`MMR_A_MODE, 64'h1);
    rd(`MMR_A_MODE, rv);
    chk(rv, 64'h1);
    wr(`MMR_A_MAF, 64'h0);
    MAF_IN <= '0;
    repeat (3) @(posedge CLK);
    MAF_IN.wb_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
      #1;
    end
    while (MAF_OUT.wb_age_req !== 1'b1 && n < 200);
    chk(64'(n), 64'd64);
    if (n == 200) stop_test();
    wr(`MMR_A_MAF, 64'h10);
    n = 0;
    repeat (80)
    begin
      @(posedge CLK);
      #1 if (MAF_OUT.wb_age_req !== 1'b0) n++;
    end
    chk(64'(n), 64'd0);
    @(posedge CLK) MAF_IN.ldl_issue <= 1'b1;
    @(posedge CLK) MAF_IN.ldl_issue <= 1'b0;
    #1 chk(MAF_OUT.wb_age_req, 1'b1);
    @(posedge CLK) MAF_IN.wb_alloc <= 1'b1;
    @(posedge CLK) MAF_IN.wb_alloc <= 1'b0;
    #1 chk(MAF_OUT.wb_age_req, 1'b1);
    @(posedge CLK);
    #1 chk(MAF_OUT.wb_age_req, 1'b0);
    $display("aging test done");
    stop_test();
  end
endmodule

bind mmr_top mmr_chk i_chk (.CLK, .RST, .TMO_RST, .ADDR, .WDATA, .WR,
  .SH_AMT_IN, .SH_AMT, .DC_IN, .DC_OUT, .L1D_FLUSH_TRIGGER_ALL, .MAF_IN, .MAF_OUT);
